// ### hw/odc_output_pair_delay.sv
// Top of the output pair delay configuration: AXI4-Lite slave and pair paths.
// Assumes a single mclk domain, asynchronous active-high reset, one master.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module odc_output_pair_delay #(
    parameter int ADDR_W   = 12,
    parameter int DDLY_MAX = odc_pkg::DDLY_MAX
) (
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [ADDR_W-1:0]       s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic [6:0]              sysrefIn,
    input  wire logic [6:0]              devClkIn,
    output logic [6:0]                   pairedOutput,
    output odc_pkg::odc_pair_cfg_t [6:0] pairCfg
);
    if (ADDR_W < 11 || ADDR_W > 32) begin : g_chk
        $error("ADDR_W must be 11 to 32");
    end

    // Decode: {hit, pair[2:0], slot[1:0]}
    function automatic logic [5:0] odcDecode(input logic [ADDR_W-1:0] a);
        logic [9:0] idx;
        logic [9:0] rel;
        logic       hit;
        idx = 10'(a >> 2);
        rel = idx - odc_pkg::IDX_DADLY_0;
        hit = (idx >= odc_pkg::IDX_DADLY_0)
            && (rel < 10'(odc_pkg::NUM_PAIRS * odc_pkg::PAIR_STRIDE))
            && !rel[2]
            && (a[1:0] == 2'h0)
            && ((a >> 12) == '0); // Wide buses must not alias onto the map
        return {hit, rel[5:3], rel[1:0]};
    endfunction

    // Register storage, one byte per slot and pair
    logic [7:0] hsSel_ff [odc_pkg::NUM_PAIRS];
    logic [7:0] sadly_ff [odc_pkg::NUM_PAIRS];
    logic [7:0] pd_ff    [odc_pkg::NUM_PAIRS];
    logic [7:0] dadly_ff [odc_pkg::NUM_PAIRS];

    // Write channel holding state
    logic              awHeld_ff;
    logic              wHeld_ff;
    logic [ADDR_W-1:0] awAddr_ff;
    logic [7:0]        wByte_ff;
    logic              wLane_ff;

    // Channel handshakes
    wire logic awTake = s_axi_awvalid && s_axi_awready;
    wire logic wTake  = s_axi_wvalid && s_axi_wready;
    wire logic bDone  = s_axi_bvalid && s_axi_bready;
    wire logic arTake = s_axi_arvalid && s_axi_arready;
    wire logic rDone  = s_axi_rvalid && s_axi_rready;

    // Commit once both halves of the write are held
    wire logic       doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
    wire logic [5:0] wDec    = odcDecode(awAddr_ff);
    wire logic       wHit    = wDec[5];
    wire logic [2:0] wPair   = wDec[4:2];
    wire logic [1:0] wSlot   = wDec[1:0];
    wire logic       wStore  = doWrite && wHit && wLane_ff;

    // Read decode is taken straight from the address channel
    wire logic [5:0] rDec  = odcDecode(s_axi_araddr);
    wire logic       rHit  = rDec[5];
    wire logic [2:0] rPair = rDec[4:2];
    wire logic [1:0] rSlot = rDec[1:0];
    wire logic [7:0] rByte =
        !rHit                         ? 8'h00 :
        (rSlot == odc_pkg::SUB_DADLY) ? dadly_ff[rPair] :
        (rSlot == odc_pkg::SUB_HSSEL) ? hsSel_ff[rPair] :
        (rSlot == odc_pkg::SUB_SADLY) ? sadly_ff[rPair] :
                                        pd_ff[rPair];

    // Next values of the bus answers
    wire logic [1:0]  nxt_bresp  = wHit ? odc_pkg::RESP_OKAY : odc_pkg::RESP_SLVERR;
    wire logic [1:0]  nxt_rresp  = rHit ? odc_pkg::RESP_OKAY : odc_pkg::RESP_SLVERR;
    wire logic [31:0] nxt_rdata  = {24'h000000, rByte};

    // Write address and data are taken in either order and held
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            awHeld_ff <= 1'b0;
            awAddr_ff <= '0;
        end else if (awTake) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wHeld_ff <= 1'b0;
            wByte_ff <= 8'h00;
            wLane_ff <= 1'b0;
        end else if (wTake) begin
            wHeld_ff <= 1'b1;
            wByte_ff <= s_axi_wdata[7:0];
            wLane_ff <= s_axi_wstrb[0];
        end else if (doWrite) begin
            wHeld_ff <= 1'b0;
        end
    end

    // Ready drops once a beat is held, so nothing is overwritten
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end else begin
            if (awTake) begin
                s_axi_awready <= 1'b0;
            end else if (bDone) begin
                s_axi_awready <= 1'b1;
            end
            if (wTake) begin
                s_axi_wready <= 1'b0;
            end else if (bDone) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Write response; unmapped address answers SLVERR
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= odc_pkg::RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= nxt_bresp;
        end else if (bDone) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel, one read outstanding
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= odc_pkg::RESP_OKAY;
        end else if (arTake) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= nxt_rdata;
            s_axi_rresp   <= nxt_rresp;
        end else if (rDone) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // Register file; reserved bits masked off so they read back zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < odc_pkg::NUM_PAIRS; p++) begin
                hsSel_ff[p] <= odc_pkg::RST_HSSEL;
                sadly_ff[p] <= odc_pkg::RST_SADLY;
                pd_ff[p]    <= odc_pkg::RST_PD;
                dadly_ff[p] <= odc_pkg::RST_DADLY;
            end
        end else if (wStore) begin
            case (wSlot)
                odc_pkg::SUB_DADLY: begin
                    dadly_ff[wPair] <= wByte_ff & odc_pkg::MASK_DADLY;
                end
                odc_pkg::SUB_HSSEL: begin
                    hsSel_ff[wPair] <= wByte_ff & odc_pkg::MASK_HSSEL;
                end
                odc_pkg::SUB_SADLY: begin
                    sadly_ff[wPair] <= wByte_ff & odc_pkg::MASK_SADLY;
                end
                default: begin
                    pd_ff[wPair] <= wByte_ff & odc_pkg::MASK_PD;
                end
            endcase
        end
    end

    // One path per output pair
    for (genvar g = 0; g < odc_pkg::NUM_PAIRS; g++) begin : g_pair
        odc_pair_path #(
            .DDLY_MAX (DDLY_MAX)
        ) u_path (
            .mclk         (mclk),
            .rst          (rst),
            .regHsSel     (hsSel_ff[g]),
            .regSadly     (sadly_ff[g]),
            .regPd        (pd_ff[g]),
            .regDadly     (dadly_ff[g]),
            .sysrefIn     (sysrefIn[g]),
            .devClkIn     (devClkIn[g]),
            .pairedOutput (pairedOutput[g]),
            .pairCfg      (pairCfg[g])
        );
    end

    // Checks on the register map, bus answers and pair outputs
    default clocking cbt @(posedge mclk); endclocking
    default disable iff (rst);

    localparam int B_MIN = 1;
    localparam int B_MAX = 2;

    // Helper: decoded write to pair 1 selection register (index 0x10C)
    wire logic wrPair1Sel = wStore && wPair == 3'h1 && wSlot == odc_pkg::SUB_HSSEL;

    property p_map;
        wrPair1Sel |=> hsSel_ff[1] == ($past(wByte_ff) & 8'h7F);
    endproperty
    a_map: assert property (p_map) else $error("pair 1 register not written");

    property p_rsvd;
        s_axi_rvalid && s_axi_rresp == odc_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h00000000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("refused read returned data");

    property p_rdzero;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_rdzero: assert property (p_rdzero) else $error("upper read bits set");

    property p_hsrsv;
        hsSel_ff[0][7] == 1'b0 && sadly_ff[0][7:5] == 3'h0;
    endproperty
    a_hsrsv: assert property (p_hsrsv) else $error("reserved bit stored");

    property p_pdfollow;
        1'b1 |=> pairCfg[1].digitalDelayPowerdown == $past(pd_ff[1][7]);
    endproperty
    a_pdfollow: assert property (p_pdfollow) else $error("powerdown not applied");

    property p_bresp;
        awTake && wTake |-> ##[B_MIN:B_MAX] s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response late");

    property p_unmapped;
        arTake && !rHit |=> s_axi_rvalid && s_axi_rresp == odc_pkg::RESP_SLVERR;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");

    property p_selroute;
        hsSel_ff[2][5] == 1'b0 |=> pairedOutput[2] == $past(devClkIn[2]);
    endproperty
    a_selroute: assert property (p_selroute) else $error("pair 2 route wrong");

    c_write: cover property (awTake && wTake ##[1:4] bDone);
    c_read: cover property (arTake ##[1:4] rDone);
    c_sysref: cover property (hsSel_ff[0][5] && hsSel_ff[0][4:1] == 4'h5);
    c_glitchless: cover property (pairCfg[3].glitchlessStep);
endmodule

// ### hw/odc_pair_path.sv
// One output pair: paired output routing, SYSREF delay line, delay settings.
// Assumes register values already masked and inputs synchronous to mclk.
`timescale 1ns/100ps
module odc_pair_path #(
    parameter int DDLY_MAX = odc_pkg::DDLY_MAX
) (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic [7:0]             regHsSel,
    input  wire logic [7:0]             regSadly,
    input  wire logic [7:0]             regPd,
    input  wire logic [7:0]             regDadly,
    input  wire logic                   sysrefIn,
    input  wire logic                   devClkIn,
    output logic                        pairedOutput,
    output odc_pkg::odc_pair_cfg_t      pairCfg
);
    if (DDLY_MAX < 10 || DDLY_MAX > 15) begin : g_chk
        $error("DDLY_MAX must be 10 to 15");
    end

    logic [DDLY_MAX-1:0] sysrefLine_ff;
    logic [4:0]          prevDadly_ff;
    logic                glitchless_ff;

    wire logic       selSysref = regHsSel[odc_pkg::BIT_SEL];
    wire logic [3:0] ddlyCode  = regHsSel[odc_pkg::DDLY_LSB +: 4];
    wire logic [3:0] sadlyCode = regSadly[odc_pkg::SADLY_LSB +: 4];
    wire logic [4:0] dadlyCode = regDadly[odc_pkg::DADLY_LSB +: 5];
    // Reserved codes clamp to the longest tap so the line never overruns
    wire logic [3:0] ddlyUse   = (ddlyCode > 4'(DDLY_MAX)) ? 4'(DDLY_MAX) : ddlyCode;
    wire logic       sysrefTap = (ddlyUse == 4'h0) ? sysrefIn : sysrefLine_ff[ddlyUse - 4'h1];
    wire logic       nxt_pairedOutput = selSysref ? sysrefTap : devClkIn;
    wire logic [11:0] sadlyPs = !regSadly[odc_pkg::BIT_SADLY_EN] ? 12'h000 :
        (sadlyCode == 4'h0) ? 12'h000 :
        12'(odc_pkg::SADLY_BASE_PS + odc_pkg::SADLY_STEP_PS * (int'(sadlyCode) - 1));
    wire logic [9:0] dadlyPs = regPd[odc_pkg::BIT_ADLY_PD] ? 10'h000 :
        10'(odc_pkg::DADLY_STEP_PS * int'(dadlyCode));
    wire logic dadlyStepOk = (dadlyCode - prevDadly_ff == 5'h01 || prevDadly_ff - dadlyCode == 5'h01)
        && dadlyCode >= 5'(odc_pkg::DADLY_GL_MIN) && dadlyCode <= 5'(odc_pkg::DADLY_GL_MAX)
        && prevDadly_ff >= 5'(odc_pkg::DADLY_GL_MIN) && prevDadly_ff <= 5'(odc_pkg::DADLY_GL_MAX);
    wire logic nxt_glitchless = (dadlyCode == prevDadly_ff) ? glitchless_ff :
        (!regPd[odc_pkg::BIT_ADLYG_PD] && dadlyStepOk);

    // Delay line keeps shifting in every mode, so a mode change is clean
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sysrefLine_ff <= '0;
            pairedOutput  <= 1'b0;
            prevDadly_ff  <= 5'h00;
            glitchless_ff <= 1'b0;
        end else begin
            sysrefLine_ff <= {sysrefLine_ff[DDLY_MAX-2:0], sysrefIn};
            pairedOutput  <= nxt_pairedOutput;
            prevDadly_ff  <= dadlyCode;
            glitchless_ff <= nxt_glitchless;
        end
    end

    // Settings handed to the analog delay cells
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pairCfg <= '0;
        end else begin
            pairCfg.deviceClockHalfStep            <= regHsSel[odc_pkg::BIT_DEV_HS];
            pairCfg.sysrefHalfStep                 <= regHsSel[odc_pkg::BIT_SR_HS];
            pairCfg.pairedOutputSelect             <= selSysref;
            pairCfg.digitalDelayPowerdown          <= regPd[odc_pkg::BIT_DDLY_PD];
            pairCfg.glitchlessHalfStepPowerdown    <= regPd[odc_pkg::BIT_HSG_PD];
            pairCfg.glitchlessAnalogDelayPowerdown <= regPd[odc_pkg::BIT_ADLYG_PD];
            pairCfg.analogDelayPowerdown           <= regPd[odc_pkg::BIT_ADLY_PD];
            pairCfg.sysrefAnalogDelayPs            <= sadlyPs;
            pairCfg.deviceClockAnalogDelayPs       <= dadlyPs;
            pairCfg.glitchlessStep                 <= nxt_glitchless;
        end
    end

    default clocking cbp @(posedge mclk); endclocking
    default disable iff (rst);

    property p_bypass; selSysref && ddlyCode == 4'h0 |=> pairedOutput == $past(sysrefIn); endproperty
    a_bypass: assert property (p_bypass) else $error("bypass path wrong");
    property p_ddly2; selSysref && ddlyCode == 4'h2 |=> pairedOutput == $past(sysrefIn, 3); endproperty
    a_ddly2: assert property (p_ddly2) else $error("digital delay wrong");
    property p_devsel; !selSysref |=> pairedOutput == $past(devClkIn); endproperty
    a_devsel: assert property (p_devsel) else $error("device clock route wrong");
    property p_sadly1; regSadly[4:0] == 5'h11 |=> pairCfg.sysrefAnalogDelayPs == 12'h258; endproperty
    a_sadly1: assert property (p_sadly1) else $error("SYSREF analog delay wrong");
    property p_sadlyoff; !regSadly[4] |=> pairCfg.sysrefAnalogDelayPs == 12'h000; endproperty
    a_sadlyoff: assert property (p_sadlyoff) else $error("analog delay not bypassed");
    property p_dadly; !regPd[4] && dadlyCode == 5'h17 |=> pairCfg.deviceClockAnalogDelayPs == 10'h23F; endproperty
    a_dadly: assert property (p_dadly) else $error("device analog delay wrong");
    property p_hs; 1'b1 |=> pairCfg.deviceClockHalfStep == $past(regHsSel[6]); endproperty
    a_hs: assert property (p_hs) else $error("half step wrong");
    property p_glpd; regPd[5] && $changed(dadlyCode) |=> !pairCfg.glitchlessStep; endproperty
    a_glpd: assert property (p_glpd) else $error("glitchless flagged while off");
    c_ddly: cover property (selSysref && ddlyCode == 4'hA ##1 sysrefIn);
endmodule

// ### hw/odc_pkg.sv
// Constants, field layout and carrier types for the output pair delay block.
// Assumes one 50 MHz clock domain and AXI4-Lite access to byte-wide registers.
package odc_pkg;
    localparam int NUM_PAIRS = 7;
    localparam int PAIR_STRIDE = 8;
    localparam int DDLY_MAX = 10;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_DADLY_0 = 10'h103;
    localparam logic [9:0] IDX_HSSEL_0 = 10'h104;
    localparam logic [9:0] IDX_SADLY_0 = 10'h105;
    localparam logic [9:0] IDX_PD_0    = 10'h106;

    // Slot within a pair block
    localparam logic [1:0] SUB_DADLY = 2'h0;
    localparam logic [1:0] SUB_HSSEL = 2'h1;
    localparam logic [1:0] SUB_SADLY = 2'h2;
    localparam logic [1:0] SUB_PD    = 2'h3;

    // Field positions
    localparam int BIT_DEV_HS    = 6;
    localparam int BIT_SEL       = 5;
    localparam int DDLY_LSB      = 1;
    localparam int BIT_SR_HS     = 0;
    localparam int BIT_SADLY_EN  = 4;
    localparam int SADLY_LSB     = 0;
    localparam int BIT_DDLY_PD   = 7;
    localparam int BIT_HSG_PD    = 6;
    localparam int BIT_ADLYG_PD  = 5;
    localparam int BIT_ADLY_PD   = 4;
    localparam int DADLY_LSB     = 3;

    // Reset values and writable masks
    localparam logic [7:0] RST_HSSEL  = 8'h00;
    localparam logic [7:0] RST_SADLY  = 8'h00;
    localparam logic [7:0] RST_PD     = 8'h70;
    localparam logic [7:0] RST_DADLY  = 8'h00;
    localparam logic [7:0] MASK_HSSEL = 8'h7F;
    localparam logic [7:0] MASK_SADLY = 8'h1F;
    localparam logic [7:0] MASK_PD    = 8'hF0;
    localparam logic [7:0] MASK_DADLY = 8'hF8;

    // Delay figures in picoseconds, then the glitchless device delay code range
    localparam int SADLY_BASE_PS = 600;
    localparam int SADLY_STEP_PS = 150;
    localparam int DADLY_STEP_PS = 25;
    localparam int DADLY_GL_MIN  = 1;
    localparam int DADLY_GL_MAX  = 23;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic        deviceClockHalfStep;
        logic        sysrefHalfStep;
        logic        pairedOutputSelect;
        logic        digitalDelayPowerdown;
        logic        glitchlessHalfStepPowerdown;
        logic        glitchlessAnalogDelayPowerdown;
        logic        analogDelayPowerdown;
        logic [11:0] sysrefAnalogDelayPs;
        logic [9:0]  deviceClockAnalogDelayPs;
        logic        glitchlessStep;
    } odc_pair_cfg_t;
endpackage

// ### tb/odc_output_pair_delay_bench.sv
// Bench for the output pair delay block: bus access, pair fields, SYSREF delay line.
// Assumes the hw/ package and modules are compiled first; one mclk domain.
`timescale 1ns/100ps
module odc_output_pair_delay_bench;
    logic                          mclk = 1'b0;
    logic                          rst = 1'b1;
    logic [11:0]                   awaddr = 12'h000;
    logic [11:0]                   araddr = 12'h000;
    logic [31:0]                   wdata = 32'h00000000;
    logic                          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic                          awready, wready, bvalid, arready, rvalid;
    logic [1:0]                    bresp, rresp;
    logic [31:0]                   rdata;
    logic [6:0]                    sysrefIn = 7'h00, devClkIn = 7'h00, pairedOutput;
    odc_pkg::odc_pair_cfg_t [6:0]  pairCfg;
    int                            errors = 0, tests_run = 0;

    // 50 MHz master clock
    always #10 mclk = ~mclk;

    odc_output_pair_delay #(.ADDR_W(12), .DDLY_MAX(10)) odc_output_pair_delay_inst (
        .mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sysrefIn(sysrefIn), .devClkIn(devClkIn),
        .pairedOutput(pairedOutput), .pairCfg(pairCfg));

    // Verdict and end of run, the single exit point
    task automatic stop_test;
        if (errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic tmo;
        errors++;
        $display("MISMATCH %0t bus wait ran out", $time);
        stop_test();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    // Byte address of slot s in pair p; slot 0 is the device analog delay
    function automatic logic [11:0] ad(input int p, input int s);
        return 12'(12'h40C + 32 * p + 4 * s);
    endfunction

    // Write: address and data offered together, bready held until the response
    task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        @(posedge mclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) tmo();
        r = bresp;
        bready <= 1'b0;
    endtask

    // Read with check of data and response code
    task automatic rck(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
        int n;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) tmo();
        chk(rdata, {24'h000000, e}, "read data");
        chk(32'(rresp), 32'(er), "read resp");
        rready <= 1'b0;
    endtask

    task automatic t_reset;
        for (int s = 0; s < 4; s++) rck(ad(6, s), (s == 3) ? 8'h70 : 8'h00, 2'h0);
        @(negedge mclk);
        chk(pairCfg[6].glitchlessHalfStepPowerdown, 1'b1, "hs pd");
        chk(pairCfg[6].deviceClockAnalogDelayPs, 32'h0, "dev ps off");
    endtask

    // Every pair gets its own value, read back after all are written
    task automatic t_pairs;
        logic [1:0] r;
        for (int p = 0; p < 7; p++) wr(ad(p, 1), 8'(8'h80 | (p << 1)), r);
        for (int p = 0; p < 7; p++) rck(ad(p, 1), 8'(p << 1), 2'h0);
        wr(ad(0, 2), 8'hFF, r);
        rck(ad(0, 2), 8'h1F, 2'h0);
        wr(12'h408, 8'h55, r);
        chk(32'(r), 32'h2, "unmapped write");
        rck(12'h408, 8'h00, 2'h2);
    endtask

    task automatic t_fields;
        logic [1:0] r;
        int         c[5] = '{0, 1, 2, 14, 15};
        wr(ad(1, 1), 8'h41, r);
        @(negedge mclk);
        chk(pairCfg[1].deviceClockHalfStep, 1'b1, "dev hs");
        chk(pairCfg[1].sysrefHalfStep, 1'b1, "sr hs");
        chk(pairCfg[1].pairedOutputSelect, 1'b0, "sel");
        foreach (c[i]) begin
            wr(ad(1, 2), 8'(8'h10 | c[i]), r);
            @(negedge mclk);
            chk(pairCfg[1].sysrefAnalogDelayPs, (c[i] == 0) ? 0 : 600 + 150 * (c[i] - 1), "sr ps");
        end
        wr(ad(1, 2), 8'h0F, r);
        @(negedge mclk);
        chk(pairCfg[1].sysrefAnalogDelayPs, 32'h0, "sr ps off");
        wr(ad(1, 3), 8'h80, r);
        wr(ad(1, 0), 8'hB8, r);
        @(negedge mclk);
        chk(pairCfg[1].deviceClockAnalogDelayPs, 32'd575, "dev ps");
        chk({pairCfg[1].digitalDelayPowerdown, pairCfg[1].analogDelayPowerdown}, 32'h2, "pd bits");
        rck(ad(1, 3), 8'h80, 2'h0);
        wr(ad(1, 3), 8'h10, r);
        @(negedge mclk);
        chk(pairCfg[1].deviceClockAnalogDelayPs, 32'h0, "dev ps pd");
    endtask

    // Cycles from a source step to the paired output; 16 means it never came
    task automatic lat(input int p, input bit sys, output int n);
        @(posedge mclk);
        if (sys) sysrefIn[p] <= 1'b1;
        else devClkIn[p] <= 1'b1;
        for (n = 1; n < 16; n++) begin
            @(posedge mclk);
            @(negedge mclk);
            if (pairedOutput[p] === 1'b1) break;
        end
        @(posedge mclk);
        sysrefIn <= 7'h00;
        devClkIn <= 7'h00;
        repeat (16) @(posedge mclk);
    endtask

    task automatic t_delay;
        logic [1:0] r;
        int         n;
        int         c[5] = '{0, 1, 2, 5, 10};
        foreach (c[i]) begin
            wr(ad(2, 1), 8'(8'h20 | (c[i] << 1)), r);
            lat(2, 1'b1, n);
            chk(n, (c[i] == 0) ? 1 : c[i] + 1, "sr delay");
            lat(2, 1'b0, n);
            chk(n, 16, "dev clk on sr path");
        end
        wr(ad(2, 1), 8'h0A, r);
        lat(2, 1'b0, n);
        chk(n, 1, "dev clk path");
        lat(2, 1'b1, n);
        chk(n, 16, "sr on dev path");
    endtask

    // Single-code moves are glitchless only inside 1..23 with the feature on
    task automatic t_glitch;
        logic [1:0] r;
        logic [7:0] v[8] = '{8'h00, 8'h08, 8'h30, 8'h38, 8'h48, 8'hB0, 8'hB8, 8'hC0};
        logic       e[8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        wr(ad(3, 3), 8'h00, r);
        foreach (v[i]) begin
            wr(ad(3, 0), v[i], r);
            @(negedge mclk);
            chk(pairCfg[3].glitchlessStep, e[i], "glitchless step");
        end
        wr(ad(3, 3), 8'h20, r);
        wr(ad(3, 0), 8'hB0, r);
        wr(ad(3, 0), 8'hB8, r);
        @(negedge mclk);
        chk(pairCfg[3].glitchlessStep, 1'b0, "glitchless off");
        chk(pairCfg[3].glitchlessAnalogDelayPowerdown, 1'b1, "glitchless pd");
    endtask

    // Reset for six cycles, then the scenarios in turn
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_pairs();
        t_fields();
        t_delay();
        t_glitch();
        stop_test();
    end
endmodule
